// *** dv/adcpo_capture.sv ***
// Capture logic model draining the word buffer
module adcpo_capture (
    // Clock and stall control
    input wire logic i_sys_clk,
    input wire logic i_stall,
    // Buffer drain side
    input wire logic i_out_valid,
    input wire logic [7:0] i_out_data,
    output logic o_out_ready = 1'b0,
    // Captured words
    output logic [7:0] o_last = 8'h00,
    output int o_count = 0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Ready moves off the sampling edge to avoid races
    always @(negedge i_sys_clk) o_out_ready <= !i_stall;
    always @(posedge i_sys_clk) begin
        if (i_out_valid && o_out_ready) begin
            o_last <= i_out_data;
            o_count <= o_count + 1;
        end
    end
endmodule : adcpo_capture

// *** dv/adcpo_pipeline_properties.sv ***
// Port checker of the sample output pipeline
module adcpo_props
    import adcpo_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Watched ports
    input wire adcpo_pkg::adcpo_sample_t i_sample,
    input wire logic i_low_power_request,
    input wire logic [7:0] o_data,
    input wire logic o_data_valid,
    input wire logic o_word_stb,
    input wire logic o_active,
    input wire logic o_out_valid,
    input wire logic [7:0] o_out_data,
    input wire logic i_out_ready
);
    // ***
    // Properties
    // ***
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    // Clipped code; below wins when both flags are set
    function automatic logic [7:0] clip(adcpo_sample_t s);
        return s.below_bottom ? 8'h00 : (s.above_top ? 8'hff : s.level);
    endfunction : clip
    a_word_latency:
    assert property (o_word_stb && o_data_valid |-> o_data == clip($past(i_sample, 4)))
        else $error("word does not match sample four edges back");
    a_fresh_stb:
    assert property (o_data_valid && o_active |-> o_word_stb) else $error("no fresh word");
    a_sleep_freeze:
    assert property (i_low_power_request && $past(i_low_power_request) |=> $stable(o_data))
        else $error("word moved while asleep");
    a_sleep_entry:
    assert property (i_low_power_request |=> !o_active) else $error("still active");
    a_wake_time:
    assert property ($fell(i_low_power_request) |-> !o_active [*8] ##[1:6] o_active)
        else $error("wake time wrong");
    a_valid_fill:
    assert property ($rose(o_data_valid) |-> o_active && $past(o_active) && $past(o_active, 2))
        else $error("valid before fill");
    a_fifo_hold:
    assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_data))
        else $error("buffer word not held");
    a_reset_state:
    assert property ($rose(i_rst_n) |-> o_data == 8'h00 && !o_data_valid && o_active)
        else $error("bad reset state");
    c_word: cover property (o_word_stb && o_data_valid);
    c_wake: cover property ($fell(i_low_power_request));
    c_stall: cover property (o_out_valid && !i_out_ready);
endmodule : adcpo_props

bind adcpo_pipeline adcpo_props u_props (.i_sys_clk, .i_rst_n, .i_sample,
    .i_low_power_request, .o_data, .o_data_valid, .o_word_stb, .o_active,
    .o_out_valid, .o_out_data, .i_out_ready);

// *** dv/tb_adc_sample_output_pipeline.sv ***
// Testbench of the sample output pipeline
module tb_adc_sample_output_pipeline;
    timeunit 1ns;
    timeprecision 1ns;
    import adcpo_pkg::*;
    // ***
    // Signals and instances
    // ***
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    adcpo_sample_t i_sample = 10'h0aa;
    logic i_low_power_request = 1'b0;
    logic i_stall = 1'b0;
    logic clk_halt = 1'b0;
    logic [7:0] o_data, o_out_data, cap_last;
    logic o_data_valid, o_word_stb, o_active, o_out_valid, out_ready;
    int cap_count, n_mismatch = 0, checks = 0, cycles = 0;
    adcpo_pipeline #(.WAKE_NS(1000)) uut (.i_sys_clk, .i_rst_n, .i_sample,
        .i_low_power_request, .o_data, .o_data_valid, .o_word_stb, .o_active,
        .o_out_valid, .o_out_data, .i_out_ready(out_ready));
    adcpo_capture u_cap (.i_sys_clk, .i_stall, .i_out_valid(o_out_valid),
        .i_out_data(o_out_data), .o_out_ready(out_ready), .o_last(cap_last), .o_count(cap_count));
    // 10 MHz clock; clk_halt parks it low for the halted-clock scenario
    initial forever #50 if (!clk_halt) i_sys_clk = ~i_sys_clk;
    // Hang guard, far above the hundred or so cycles needed
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 1000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    // ***
    // Tasks
    // ***
    task chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            $display("unexpected at %0t: %s", $time, m);
            n_mismatch++;
        end
    endtask : chk
    task end_of_test;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    task wt;
        for (int i = 0; i < 40 && o_data_valid !== 1'b1; i++) @(negedge i_sys_clk);
        chk(o_data_valid === 1'b1, "valid timeout");
    endtask : wt
    // Steady aa before, then codes incl. clipped ones back to back
    task automatic t_stream;
        logic [9:0] s[6] = '{10'h000, 10'h05a, 10'h0ff, 10'h277, 10'h133, 10'h344};
        logic [7:0] e[6] = '{8'h00, 8'h5a, 8'hff, 8'h00, 8'hff, 8'h00};
        for (int i = 0; i < 10; i++) begin
            @(negedge i_sys_clk);
            if (i >= 4) chk(o_data === e[i-4] && o_word_stb === 1'b1, "word");
            else chk(o_data === 8'haa, "early word");
            i_sample <= (i < 6) ? s[i] : 10'h0aa;
        end
    endtask : t_stream
    // Park the clock low; the word must stay put with no edges
    task automatic t_halt;
        logic [7:0] w;
        @(negedge i_sys_clk);
        w = o_data;
        clk_halt = 1'b1;
        #980;
        chk(o_data === w && o_data === 8'haa, "word moved while clock halted");
        clk_halt = 1'b0;
    endtask : t_halt
    // One negedge first, so the sample is not driven twice in one step
    task t_sleep;
        @(negedge i_sys_clk);
        i_low_power_request <= 1'b1;
        i_sample <= 10'h011;
        repeat (3) @(negedge i_sys_clk);
        for (int i = 0; i < 20; i++) begin
            @(negedge i_sys_clk);
            i_sample <= 10'(i);
            chk(o_data === 8'haa && o_active === 1'b0, "not frozen");
        end
        i_low_power_request <= 1'b0;
        i_sample <= 10'h0aa;
        for (int i = 0; i < 11; i++) begin
            @(negedge i_sys_clk);
            chk(o_data_valid === 1'b0, "valid while waking");
        end
        wt();
    endtask : t_sleep
    // Fill while stalled, then sleep and drain to empty
    task t_fifo;
        int n;
        @(negedge i_sys_clk);
        i_stall <= 1'b1;
        i_rst_n <= 1'b0;
        i_sample <= 10'h0c3;
        repeat (2) @(negedge i_sys_clk);
        i_rst_n <= 1'b1;
        repeat (20) @(negedge i_sys_clk);
        chk(o_out_valid === 1'b1, "buffer empty");
        i_low_power_request <= 1'b1;
        repeat (3) @(negedge i_sys_clk);
        n = cap_count;
        i_stall <= 1'b0;
        repeat (10) @(negedge i_sys_clk);
        chk(cap_count - n == 4 && cap_last === 8'hc3 && o_out_valid === 1'b0, "drain");
    endtask : t_fifo
    // Main sequence
    initial begin
        repeat (10) @(negedge i_sys_clk);
        chk(o_active === 1'b1 && o_data === 8'h00 && o_data_valid === 1'b0, "reset");
        i_rst_n <= 1'b1;
        wt();
        t_stream();
        t_halt();
        t_sleep();
        t_stream();
        t_fifo();
        end_of_test();
    end
endmodule : tb_adc_sample_output_pipeline

// *** rtl/adcpo_fifo.sv ***
// Small valid/ready FIFO for converted words
module adcpo_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } adcpo_fifo_st_t;
    adcpo_fifo_st_t st_ff;
    adcpo_fifo_st_t nxt_st;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic push;
    logic pop;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("adcpo_fifo: DEPTH must be a power of two, at least 2");
        end
    end

    // Honest full and empty from the occupancy count
    assign o_in_ready = (st_ff.cnt != DEPTH[AW:0]);
    assign o_out_valid = (st_ff.cnt != '0);
    assign o_out_data = mem_ff[st_ff.rd];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Pointer and count update
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wr = st_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd = st_ff.rd + 1'b1;
        end
        if (push && !pop) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end else if (pop && !push) begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Storage has no reset; it is never read while empty
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem_ff[st_ff.wr] <= i_in_data;
        end
    end
endmodule : adcpo_fifo

// *** rtl/adcpo_pipeline.sv ***
// Sample output pipeline of an 8-bit sampling converter
// Overview of operation
// - Take each sample at the falling clock edge; hold begins just after.
// - Result appears two and a half cycles after the sampling edge.
// - A fresh result every clock cycle once the pipeline is full.
// - Output word changes on the rising clock edge.
// - Eight-bit straight binary, zero at bottom, all ones at top reference.
// - Below bottom gives all zeros; above top gives all ones.
// - Converts continuously while the clock runs, no start command.
// - Active converting state while the low-power request is low.
// - Low-power request high freezes output at the last result.
// - Outputs invalid for about one microsecond after wake-up.
// - A stopped clock keeps the same output word.
`include "adcpo_defines.svh"
module adcpo_pipeline
    import adcpo_pkg::*;
#(
    parameter int DATA_W = `ADCPO_DATA_W,
    parameter int FIFO_DEPTH = `ADCPO_FIFO_DEPTH,
    parameter int CLK_HZ = `ADCPO_CLK_HZ,
    parameter int WAKE_NS = `ADCPO_WAKE_NS
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Analog front end, already quantised
    input wire adcpo_pkg::adcpo_sample_t i_sample,
    // Power control
    input wire logic i_low_power_request,
    // Output word toward the capture logic
    output logic [DATA_W-1:0] o_data,
    output logic o_data_valid,
    output logic o_word_stb,
    output logic o_active,
    // Word stream through the buffer
    output logic o_out_valid,
    output logic [DATA_W-1:0] o_out_data,
    input wire logic i_out_ready
);
    import adcpo_pkg::*;

    // ****************************************
    // Constants and checks
    // ****************************************
    // Wake wait rounds up to whole cycles, never below one
    localparam longint WAKE_RAW = (longint'(WAKE_NS) * CLK_HZ + 999_999_999) / 1_000_000_000;
    localparam int WAKE_CYC = (WAKE_RAW < 1) ? 1 : int'(WAKE_RAW);
    localparam int WW = $clog2(WAKE_CYC + 1);

    initial begin
        if (DATA_W != `ADCPO_DATA_W) begin
            $error("adcpo_pipeline: output word is fixed at eight bits");
        end
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [DATA_W-1:0] held;      // Sample caught on the falling edge
        logic [DATA_W-1:0] stage1;
        logic [DATA_W-1:0] word;
        logic [`ADCPO_PIPE_STAGES:0] fill;
        adcpo_pwr_t pwr;
        logic [WW-1:0] wake_cnt;
        logic valid;
        logic stb;
    } adcpo_st_t;
    adcpo_st_t st_ff;
    adcpo_st_t nxt_st;
    logic [DATA_W-1:0] held_neg_ff;
    logic fifo_in_ready;

    // Clip an out-of-range sample to the rail codes
    // rail code clipping
    function automatic logic [DATA_W-1:0] adcpo_quantise(input adcpo_sample_t s);
        logic [DATA_W-1:0] q;
        q = s.level;
        if (s.below_bottom) begin
            q = `ADCPO_CODE_ZERO;
        end else if (s.above_top) begin
            q = `ADCPO_CODE_FULL;
        end
        return q;
    endfunction : adcpo_quantise

    // ****************************************
    // Sampling
    // ****************************************
    // falling edge hold; the half cycle of latency comes from here
    always_ff @(negedge i_sys_clk) begin
        if (!i_low_power_request) begin
            held_neg_ff <= adcpo_quantise(i_sample);
        end
    end

    // ****************************************
    // Pipeline and power control
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.stb = 1'b0;
        nxt_st.held = held_neg_ff;
        case (st_ff.pwr)
            ADCPO_ACTIVE: begin
                // shift every rising edge, no start command
                nxt_st.stage1 = st_ff.held;
                // output updates on rising edge, 2.5 cycles total
                nxt_st.word = st_ff.stage1;
                nxt_st.stb = 1'b1;
                nxt_st.fill = {st_ff.fill[`ADCPO_PIPE_STAGES-1:0], 1'b1};
                nxt_st.valid = st_ff.fill[`ADCPO_PIPE_STAGES];
                if (i_low_power_request) begin
                    // freeze the last word; level input, no ack
                    nxt_st.word = st_ff.word;
                    nxt_st.stb = 1'b0;
                    nxt_st.valid = 1'b0;
                    nxt_st.pwr = ADCPO_ASLEEP;
                end
            end
            ADCPO_ASLEEP: begin
                if (!i_low_power_request) begin
                    nxt_st.pwr = ADCPO_WAKING;
                    nxt_st.wake_cnt = '0;
                    nxt_st.fill = '0;
                end
            end
            ADCPO_WAKING: begin
                // hold off valid words for the settling time
                if (i_low_power_request) begin
                    nxt_st.pwr = ADCPO_ASLEEP;
                end else if (st_ff.wake_cnt == WW'(WAKE_CYC - 1)) begin
                    nxt_st.pwr = ADCPO_ACTIVE;
                end else begin
                    nxt_st.wake_cnt = st_ff.wake_cnt + 1'b1;
                end
            end
            default: begin
                nxt_st.pwr = ADCPO_ASLEEP;
            end
        endcase
        // Back-pressure: a full buffer leaves strobe and validity flag unchanged; the word is just not pushed
        if (!fifo_in_ready) begin
            nxt_st.stb = nxt_st.stb;
        end
    end

    // no clock means no edge, so every register simply keeps its value
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_data = st_ff.word;
    assign o_data_valid = st_ff.valid;
    assign o_word_stb = st_ff.stb;
    assign o_active = (st_ff.pwr == ADCPO_ACTIVE);

    // ****************************************
    // Output buffer
    // ****************************************
    // only settled words enter the stream
    adcpo_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(st_ff.stb && st_ff.valid),
        .i_in_data(st_ff.word),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(o_out_valid),
        .o_out_data(o_out_data),
        .i_out_ready(i_out_ready)
    );
endmodule : adcpo_pipeline

// *** shared/adcpo_defines.svh ***
// Constants of the sample output pipeline
`ifndef ADCPO_DEFINES_SVH
`define ADCPO_DEFINES_SVH
`define ADCPO_DATA_W 8
`define ADCPO_CODE_ZERO 8'h00
`define ADCPO_CODE_FULL 8'hFF
`define ADCPO_CLK_HZ 10_000_000
`define ADCPO_WAKE_NS 1000
`define ADCPO_FIFO_DEPTH 4
`define ADCPO_PIPE_STAGES 2
`endif

// *** shared/adcpo_pkg.sv ***
// Types of the sample output pipeline
package adcpo_pkg;
    // One analog sample as seen by the digital side
    typedef struct packed {
        logic below_bottom;
        logic above_top;
        logic [7:0] level;
    } adcpo_sample_t;
    // Power state
    typedef enum logic [1:0] {
        ADCPO_ACTIVE = 2'b00,
        ADCPO_WAKING = 2'b01,
        ADCPO_ASLEEP = 2'b11
    } adcpo_pwr_t;
endpackage : adcpo_pkg
